// ### common/cat_pkg.sv
// Shared constants and types for the counter array timebase block
package cat_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CNT_LO = 8'h00;
    localparam logic [7:0] OFF_CNT_HI = 8'h04;
    localparam logic [7:0] OFF_MODE = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_MASK = 8'h10;
    localparam logic [7:0] OFF_CYCLEN = 8'h14;
    localparam logic [7:0] OFF_CH_BASE = 8'h20;
    localparam logic [7:0] OFF_CH_STRIDE = 8'h10;
    localparam logic [7:0] OFF_CH_CFG = 8'h00;
    localparam logic [7:0] OFF_CH_LO = 8'h04;
    localparam logic [7:0] OFF_CH_HI = 8'h08;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int MODE_TB_LSB = 1;
    localparam int MODE_WDT_BIT = 6;
    localparam int MODE_IDLE_BIT = 7;
    localparam int ST_WRAP = 0;
    localparam int ST_MID = 1;
    localparam int ST_CH0 = 2;
    localparam int NUM_CH = 3;
    localparam int WDT_CH = 2;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [2:0] TB_RST = 3'h0;
    localparam logic IDLE_RST = 1'b0;
    localparam logic WDT_RST = 1'b1;
    localparam logic [4:0] MASK_RST = 5'h00;
    localparam logic [1:0] CYCLEN_RST = 2'h0;

    // ----------------------------------------------------------------
    // Timebase codes and prescaler counts
    // ----------------------------------------------------------------
    localparam logic [2:0] TB_DIV12 = 3'h0;
    localparam logic [2:0] TB_DIV4 = 3'h1;
    localparam logic [2:0] TB_T0OVF = 3'h2;
    localparam logic [2:0] TB_EXTIN = 3'h3;
    localparam logic [2:0] TB_SYSCLK = 3'h4;
    localparam logic [2:0] TB_EXTOSC = 3'h5;
    localparam logic [2:0] TB_RTC = 3'h6;
    localparam logic [3:0] PRE_LAST = 4'hb;
    localparam logic [1:0] PRE_DIV4_HIT = 2'h3;

    // Channel configuration, low bits of the channel config register
    typedef struct packed {
        logic toggle;
        logic match_en;
        logic cap_neg;
        logic cap_pos;
    } cat_chan_cfg_t;

endpackage : cat_pkg

// ### src/cat_timebase.sv
// Counter increment source selection and prescaling
`timescale 1ns/1ps
`default_nettype none
module cat_timebase (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [2:0] sel_i,
    input wire logic timer0_ovf_i,
    input wire logic ext_count_i,
    input wire logic ext_osc_div8_i,
    input wire logic rtc_osc_div8_i,
    output logic tick_o
);
    logic [3:0] pre;
    logic ext_prev;
    logic [2:0] osc_sync;
    logic [2:0] rtc_sync;
    logic next_tick;

    // Free running divide by twelve prescaler
    always_ff @(posedge mclk_i)
    begin
        if (rst_i || pre == cat_pkg::PRE_LAST)
            pre <= 4'h0;
        else
            pre <= pre + 4'h1;
    end

    // R6 - synchronise oscillator sources
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            osc_sync <= 3'h0;
            rtc_sync <= 3'h0;
            ext_prev <= 1'b0;
        end
        else
        begin
            osc_sync <= {osc_sync[1:0], ext_osc_div8_i};
            rtc_sync <= {rtc_sync[1:0], rtc_osc_div8_i};
            ext_prev <= ext_count_i;
        end
    end

    // R4 - select increment source
    always_comb
    begin
        case (sel_i)
            cat_pkg::TB_DIV12: next_tick = (pre == cat_pkg::PRE_LAST);
            cat_pkg::TB_DIV4: next_tick = (pre[1:0] == cat_pkg::PRE_DIV4_HIT);
            cat_pkg::TB_T0OVF: next_tick = timer0_ovf_i;
            // R5 - falling edge count
            cat_pkg::TB_EXTIN: next_tick = ext_prev & ~ext_count_i;
            cat_pkg::TB_SYSCLK: next_tick = 1'b1;
            cat_pkg::TB_EXTOSC: next_tick = osc_sync[1] & ~osc_sync[2];
            cat_pkg::TB_RTC: next_tick = rtc_sync[1] & ~rtc_sync[2];
            default: next_tick = 1'b0; // Reserved code never counts
        endcase
    end

    // Registered increment pulse
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            tick_o <= 1'b0;
        else
            tick_o <= next_tick;
    end
endmodule : cat_timebase
`default_nettype wire

// ### src/cat_channel.sv
// One capture/compare channel sharing the array counter
`timescale 1ns/1ps
`default_nettype none
module cat_channel (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire cat_pkg::cat_chan_cfg_t cfg_i,
    input wire logic [15:0] cnt_i,
    input wire logic [15:0] next_cnt_i,
    input wire logic run_i,
    input wire logic wr_lo_i,
    input wire logic wr_hi_i,
    input wire logic [7:0] wdat_i,
    input wire logic io_i,
    output logic [15:0] cmp_o,
    output logic event_o,
    output logic io_o
);
    logic io_prev;
    logic capture;
    logic match;

    // Edge and match detection
    assign capture = (cfg_i.cap_pos & io_i & ~io_prev)
                   | (cfg_i.cap_neg & ~io_i & io_prev);
    assign match = cfg_i.match_en & run_i & (next_cnt_i == cmp_o);

    // Compare register, software write beats capture
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            cmp_o <= 16'h0000;
        else if (wr_lo_i)
            cmp_o[7:0] <= wdat_i;
        else if (wr_hi_i)
            cmp_o[15:8] <= wdat_i;
        else if (capture)
            cmp_o <= cnt_i;
    end

    // Event pulse and toggled pin
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            io_prev <= 1'b0;
            event_o <= 1'b0;
            io_o <= 1'b0;
        end
        else
        begin
            io_prev <= io_i;
            event_o <= capture | match;
            if (match && cfg_i.toggle)
                io_o <= ~io_o;
        end
    end
endmodule : cat_channel
`default_nettype wire

// ### src/cat_counter_array.sv
// Counter array timebase: 16-bit counter, flags, channels, Wishbone slave
//
// The implementer's own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1 - Sixteen bit up-counter, readable and writable as low and high bytes.
// R2 - Reading low byte snapshots high byte; next high read returns snapshot.
// R3 - Byte reads never pause or disturb counting.
// R4 - Three bit select picks clock/12, /4, timer0, ext fall, clock, osc/8, rtc/8.
// R5 - External count input advances on falling edges, at most clock/4.
// R6 - Oscillator and rtc divided sources are synchronised to the clock.
// R7 - Rolling from all ones to zero sets the overflow flag.
// R8 - Overflow flag requests interrupt only when its enable is set.
// R9 - Overflow flag stays set until software clears it.
// R10 - With idle suspend clear, counting continues in idle mode.
// R11 - With idle suspend set, counter holds during idle mode.
// R12 - Intermediate flag sets on overflow out of bit 8 to 11; the code flags the carry out of bit 7 to 10 (into bit 8 to 11).
// R13 - Cycle length select 00..11 picks bit 8 through bit 11.
// R14 - All five flags set on their trigger regardless of enables.
// R15 - Each flag reaches the single interrupt only through its own enable.
// R16 - Processor honours interrupt only with global and array enables set.
// R17 - Three 16-bit capture/compare channels share counter, each with I/O line.
// R18 - Channel 2 starts in watchdog mode after reset; writes restricted then.
module cat_counter_array (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    output logic irq_o,
    input wire logic idle_mode_i,
    input wire logic timer0_ovf_i,
    input wire logic external_count_input_i,
    input wire logic ext_osc_div8_i,
    input wire logic rtc_osc_div8_i,
    input wire logic [2:0] channel_io_line_i,
    output logic [2:0] channel_io_line_o,
    output logic [2:0] channel_io_line_oe_n_o,
    output logic wdt_reset_o
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic [7:0] snapshot;
    logic [2:0] timebase_select;
    logic idle_suspend;
    logic wdt_enable;
    logic [1:0] cycle_length_select;
    logic [4:0] status;
    logic [4:0] mask;
    logic [4:0] next_status;
    logic [4:0] set_ev;
    logic [4:0] clr_ev;
    logic tick;
    logic run;
    logic access;
    logic wr;
    logic rd_take;
    logic [31:0] next_rdata;
    logic [7:0] wdat;
    logic [2:0] ch_event;
    logic [2:0] ch_wr_lo;
    logic [2:0] ch_wr_hi;
    logic [15:0] ch_cmp [3];
    logic [2:0] ch_pin;
    cat_pkg::cat_chan_cfg_t ch_cfg [3];

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    // Byte address of a channel register
    function automatic logic [7:0] ch_addr(input int n, input logic [7:0] off);
        ch_addr = cat_pkg::OFF_CH_BASE + off + 8'(n * 16);
    endfunction : ch_addr

    // Low bits that must all be ones for an intermediate overflow
    function automatic logic [15:0] ovf_span(input logic [1:0] sel);
        case (sel)
            2'h0: ovf_span = 16'h00ff;
            2'h1: ovf_span = 16'h01ff;
            2'h2: ovf_span = 16'h03ff;
            default: ovf_span = 16'h07ff;
        endcase
    endfunction : ovf_span

    // ----------------------------------------------------------------
    // Wishbone slave
    // ----------------------------------------------------------------
    // Writes complete on the edge that sees ack high, reads latch data on the edge that raises ack
    assign access = wb_cyc_i & wb_stb_i;
    assign wr = access & wb_ack_o & wb_we_i & wb_sel_i[0];
    assign rd_take = access & ~wb_ack_o & ~wb_we_i;
    assign wdat = wb_dat_i[7:0];

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= access & ~wb_ack_o;
    end

    // Read multiplexer, unmapped addresses read zero
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        case (wb_adr_i)
            cat_pkg::OFF_CNT_LO: next_rdata[7:0] = cnt[7:0];
            // R2 - high byte from snapshot
            cat_pkg::OFF_CNT_HI: next_rdata[7:0] = snapshot;
            cat_pkg::OFF_MODE:
            begin
                next_rdata[cat_pkg::MODE_TB_LSB +: 3] = timebase_select;
                next_rdata[cat_pkg::MODE_WDT_BIT] = wdt_enable;
                next_rdata[cat_pkg::MODE_IDLE_BIT] = idle_suspend;
            end
            cat_pkg::OFF_STATUS: next_rdata[4:0] = status;
            cat_pkg::OFF_MASK: next_rdata[4:0] = mask;
            cat_pkg::OFF_CYCLEN: next_rdata[1:0] = cycle_length_select;
            default: next_rdata = 32'h0000_0000;
        endcase
        for (int n = 0; n < cat_pkg::NUM_CH; n++)
        begin
            if (wb_adr_i == ch_addr(n, cat_pkg::OFF_CH_CFG))
                next_rdata[3:0] = ch_cfg[n];
            if (wb_adr_i == ch_addr(n, cat_pkg::OFF_CH_LO))
                next_rdata[7:0] = ch_cmp[n][7:0];
            if (wb_adr_i == ch_addr(n, cat_pkg::OFF_CH_HI))
                next_rdata[7:0] = ch_cmp[n][15:8];
        end
    end

    // Read data register, loaded as ack rises
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            wb_dat_o <= 32'h0000_0000;
        else if (rd_take)
            wb_dat_o <= next_rdata;
    end

    // R2 - latch high byte on low read
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            snapshot <= 8'h00;
        else if (rd_take && wb_adr_i == cat_pkg::OFF_CNT_LO)
            snapshot <= cnt[15:8];
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // Mode register
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            timebase_select <= cat_pkg::TB_RST;
            idle_suspend <= cat_pkg::IDLE_RST;
            // R18 - watchdog on after reset
            wdt_enable <= cat_pkg::WDT_RST;
        end
        else if (wr && wb_adr_i == cat_pkg::OFF_MODE)
        begin
            wdt_enable <= wdat[cat_pkg::MODE_WDT_BIT];
            // R18 - mode locked by watchdog
            if (!wdt_enable)
            begin
                timebase_select <= wdat[cat_pkg::MODE_TB_LSB +: 3];
                idle_suspend <= wdat[cat_pkg::MODE_IDLE_BIT];
            end
        end
    end

    // Mask and cycle length registers
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            mask <= cat_pkg::MASK_RST;
            cycle_length_select <= cat_pkg::CYCLEN_RST;
        end
        else if (wr)
        begin
            if (wb_adr_i == cat_pkg::OFF_MASK)
                mask <= wdat[4:0];
            if (wb_adr_i == cat_pkg::OFF_CYCLEN)
                cycle_length_select <= wdat[1:0];
        end
    end

    // Channel configuration registers, channel 2 locked by watchdog
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            for (int n = 0; n < cat_pkg::NUM_CH; n++)
                ch_cfg[n] <= '0;
        end
        else
        begin
            for (int n = 0; n < cat_pkg::NUM_CH; n++)
            begin
                // R18 - restrict watchdog channel
                if (wr && wb_adr_i == ch_addr(n, cat_pkg::OFF_CH_CFG)
                    && !(wdt_enable && n == cat_pkg::WDT_CH))
                    ch_cfg[n] <= wdat[3:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    cat_timebase u_timebase (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .sel_i(timebase_select),
        .timer0_ovf_i(timer0_ovf_i),
        .ext_count_i(external_count_input_i),
        .ext_osc_div8_i(ext_osc_div8_i),
        .rtc_osc_div8_i(rtc_osc_div8_i),
        .tick_o(tick)
    );

    // R10 - idle only stops when suspend set
    // R11 - hold count in idle
    assign run = tick & ~(idle_suspend & idle_mode_i);
    assign next_cnt = cnt + 16'h0001;

    // R1 - byte writable up-counter
    // R3 - reads never touch the count
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            cnt <= 16'h0000;
        else if (wr && wb_adr_i == cat_pkg::OFF_CNT_LO)
            cnt[7:0] <= wdat;
        else if (wr && wb_adr_i == cat_pkg::OFF_CNT_HI)
            cnt[15:8] <= wdat;
        else if (run)
            cnt <= next_cnt;
    end

    // ----------------------------------------------------------------
    // Capture/compare channels
    // ----------------------------------------------------------------
    // R17 - three channels on one counter
    generate
        for (genvar g = 0; g < cat_pkg::NUM_CH; g++)
        begin : g_ch
            assign ch_wr_lo[g] = wr && wb_adr_i == ch_addr(g, cat_pkg::OFF_CH_LO);
            assign ch_wr_hi[g] = wr && wb_adr_i == ch_addr(g, cat_pkg::OFF_CH_HI);
            cat_channel u_ch (
                .mclk_i(mclk_i),
                .rst_i(rst_i),
                .cfg_i(ch_cfg[g]),
                .cnt_i(cnt),
                .next_cnt_i(next_cnt),
                .run_i(run),
                .wr_lo_i(ch_wr_lo[g]),
                .wr_hi_i(ch_wr_hi[g]),
                .wdat_i(wdat),
                .io_i(channel_io_line_i[g]),
                .cmp_o(ch_cmp[g]),
                .event_o(ch_event[g]),
                .io_o(ch_pin[g])
            );
        end
    endgenerate

    // Pin outputs, enable low while a channel toggles its line
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            channel_io_line_o <= 3'h0;
            channel_io_line_oe_n_o <= 3'h7;
        end
        else
        begin
            channel_io_line_o <= ch_pin;
            for (int n = 0; n < cat_pkg::NUM_CH; n++)
                channel_io_line_oe_n_o[n] <= ~ch_cfg[n].toggle;
        end
    end

    // Watchdog reset when counter high byte reaches channel 2 high byte
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            wdt_reset_o <= 1'b0;
        else
            wdt_reset_o <= wdt_enable & run
                         & (next_cnt[15:8] == ch_cmp[cat_pkg::WDT_CH][15:8]);
    end

    // ----------------------------------------------------------------
    // Event flags and interrupt
    // ----------------------------------------------------------------
    // R7 - overflow on roll to zero
    // R12 - intermediate overflow
    // R13 - bit chosen by cycle length
    // R14 - flags set regardless of enable
    always_comb
    begin
        set_ev = 5'h00;
        set_ev[cat_pkg::ST_WRAP] = run & (cnt == 16'hffff);
        set_ev[cat_pkg::ST_MID] = run
            & ((cnt & ovf_span(cycle_length_select)) == ovf_span(cycle_length_select));
        set_ev[cat_pkg::ST_CH0 +: 3] = ch_event;
        clr_ev = (wr && wb_adr_i == cat_pkg::OFF_STATUS) ? wdat[4:0] : 5'h00;
        next_status = (status & ~clr_ev) | set_ev;
    end

    // R9 - sticky until software clear
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            status <= 5'h00;
        else
            status <= next_status;
    end

    // R8 - overflow gated by its enable
    // R15 - per flag enable into one line
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(status & mask);
    end
endmodule : cat_counter_array
`default_nettype wire

// ### sim/cat_counter_array_asserts.sv
// Port checker for the counter array timebase, bound to the top module
`timescale 1ns/1ps
`default_nettype none
module cat_counter_array_asserts (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic irq_o,
    input wire logic [2:0] channel_io_line_oe_n_o,
    input wire logic wdt_reset_o
);
    // -------------------------------------------------------------
    // Bus answer and reset state
    // -------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
    property p_ack_cause;
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
    property p_byte_wide;
        wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000;
    endproperty
    a_byte_wide: assert property (p_byte_wide) else $error("read not byte");
    property p_unmapped;
        wb_ack_o && !wb_we_i && wb_adr_i == 8'h18 |-> wb_dat_o == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_rst_quiet;
        $fell(rst_i) |-> !irq_o && !wdt_reset_o && channel_io_line_oe_n_o == 3'h7;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("reset state");
    property p_wdt_pulse;
        wdt_reset_o |=> !wdt_reset_o;
    endproperty
    a_wdt_pulse: assert property (p_wdt_pulse) else $error("wdt pulse");
    // Sticky flag keeps the request up without bus writes
    property p_irq_sticky;
        (!wb_cyc_i) [*3] ##0 irq_o |=> irq_o;
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("irq dropped");
    c_irq: cover property ($rose(irq_o));
    c_write: cover property (wb_ack_o && wb_we_i);
    c_status: cover property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h0c);
endmodule : cat_counter_array_asserts

bind cat_counter_array cat_counter_array_asserts u_asserts (.mclk_i(mclk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .irq_o(irq_o),
    .channel_io_line_oe_n_o(channel_io_line_oe_n_o), .wdt_reset_o(wdt_reset_o));
`default_nettype wire

// ### sim/cat_counter_array_tb_top.sv
// Self-checking testbench for the counter array timebase
`timescale 1ns/1ps
`default_nettype none
module cat_counter_array_tb_top;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic idle = 1'b0;
    logic [3:0] src = 4'h4;
    logic [2:0] io_in = 3'h0;
    logic ack;
    logic irq;
    logic [31:0] rdat;
    logic [2:0] io_o;
    logic [2:0] oe_n;
    logic [31:0] rd;
    int n_fail = 0;
    int check_count = 0;
    // Device under test
    cat_counter_array DUT (.mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_ack_o(ack),
        .wb_dat_o(rdat), .irq_o(irq), .idle_mode_i(idle), .timer0_ovf_i(src[0]),
        .external_count_input_i(src[2]), .ext_osc_div8_i(src[1]), .rtc_osc_div8_i(src[3]),
        .channel_io_line_i(io_in), .channel_io_line_o(io_o), .channel_io_line_oe_n_o(oe_n),
        .wdt_reset_o());
    // Clock, 100 ns period
    initial
    begin
        forever #50 mclk_i = ~mclk_i;
    end
    // -------------------------------------------------------------
    // Shared helpers
    // -------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    // Classic single Wishbone cycle, byte lane 0
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        sel <= 4'h1;
        do
        begin
            @(posedge mclk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        check({31'h0, ack}, 32'h1, "ack");
        rd = rdat;
        cyc <= 1'b0;
        we <= 1'b0;
        @(posedge mclk_i);
    endtask : wb
    task automatic mode(input logic [2:0] code, input logic isus);
        wb(1'b1, cat_pkg::OFF_MODE, {isus, 3'h0, code, 1'b0});
    endtask : mode
    // Stop, load and clear flags
    task automatic setc(input logic [15:0] v);
        mode(3'h7, 1'b0);
        wb(1'b1, cat_pkg::OFF_CNT_HI, v[15:8]);
        wb(1'b1, cat_pkg::OFF_CNT_LO, v[7:0]);
        wb(1'b1, cat_pkg::OFF_STATUS, 8'h1f);
    endtask : setc
    // Low byte advance over 48 cycles
    task automatic t_step(input logic [2:0] code, input logic isus, input int idx,
        input logic [7:0] exp);
        logic [7:0] a;
        logic hi;
        mode(code, isus);
        wb(1'b0, cat_pkg::OFF_CNT_LO, 8'h00);
        a = rd[7:0];
        for (int c = 0; c < 40; c++)
        begin
            hi = (idx == 0) ? (c % 8 == 0) : (c % 8 < 4);
            if (idx < 4)
                src[idx] <= (idx == 2) ? !hi : hi;
            @(posedge mclk_i);
        end
        repeat (5) @(posedge mclk_i);
        wb(1'b0, cat_pkg::OFF_CNT_LO, 8'h00);
        check({24'h0, rd[7:0] - a}, {24'h0, exp}, "count step");
    endtask : t_step
    task automatic run_from(input logic [15:0] v, input logic [31:0] exp);
        setc(v);
        mode(cat_pkg::TB_SYSCLK, 1'b0);
        repeat (10) @(posedge mclk_i);
        mode(3'h7, 1'b0);
        wb(1'b0, cat_pkg::OFF_STATUS, 8'h00);
        check(rd & 32'h2, exp, "mid flag");
    endtask : run_from
    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    task automatic t_reset();
        wb(1'b0, cat_pkg::OFF_MODE, 8'h00);
        check(rd, 32'h40, "mode reset");
        wb(1'b0, cat_pkg::OFF_MASK, 8'h00);
        check(rd, 32'h0, "mask reset");
        wb(1'b0, 8'h18, 8'h00);
        check(rd, 32'h0, "unmapped");
        mode(cat_pkg::TB_SYSCLK, 1'b0);
        wb(1'b0, cat_pkg::OFF_MODE, 8'h00);
        check(rd, 32'h0, "watchdog lock");
    endtask : t_reset
    task automatic t_snap();
        setc(16'h12f0);
        mode(cat_pkg::TB_SYSCLK, 1'b0);
        wb(1'b0, cat_pkg::OFF_CNT_LO, 8'h00);
        repeat (30) @(posedge mclk_i);
        wb(1'b0, cat_pkg::OFF_CNT_HI, 8'h00);
        check(rd, 32'h12, "snapshot");
        wb(1'b0, cat_pkg::OFF_CNT_LO, 8'h00);
        wb(1'b0, cat_pkg::OFF_CNT_HI, 8'h00);
        check(rd, 32'h13, "carry to high");
    endtask : t_snap
    task automatic t_ovf();
        setc(16'hfff0);
        mode(cat_pkg::TB_SYSCLK, 1'b0);
        repeat (30) @(posedge mclk_i);
        wb(1'b0, cat_pkg::OFF_STATUS, 8'h00);
        check(rd & 32'h3, 32'h3, "wrap flags");
        check({31'h0, irq}, 32'h0, "masked");
        wb(1'b1, cat_pkg::OFF_MASK, 8'h01);
        repeat (2) @(posedge mclk_i);
        check({31'h0, irq}, 32'h1, "enabled");
        wb(1'b1, cat_pkg::OFF_STATUS, 8'h00);
        repeat (2) @(posedge mclk_i);
        check({31'h0, irq}, 32'h1, "zero write");
        wb(1'b1, cat_pkg::OFF_STATUS, 8'h01);
        repeat (2) @(posedge mclk_i);
        check({31'h0, irq}, 32'h0, "cleared");
        wb(1'b1, cat_pkg::OFF_MASK, 8'h02);
        repeat (2) @(posedge mclk_i);
        check({31'h0, irq}, 32'h1, "mid irq");
        wb(1'b1, cat_pkg::OFF_MASK, 8'h00);
    endtask : t_ovf
    task automatic t_chan();
        setc(16'h0000);
        wb(1'b1, cat_pkg::OFF_CH_BASE, 8'h0c);
        wb(1'b1, cat_pkg::OFF_CH_BASE + cat_pkg::OFF_CH_LO, 8'h10);
        wb(1'b1, cat_pkg::OFF_CH_BASE + cat_pkg::OFF_CH_HI, 8'h00);
        check({31'h0, oe_n[0]}, 32'h0, "pin driven");
        wb(1'b1, 8'h30, 8'h01);
        io_in <= 3'h2;
        mode(cat_pkg::TB_SYSCLK, 1'b0);
        repeat (30) @(posedge mclk_i);
        wb(1'b0, cat_pkg::OFF_STATUS, 8'h00);
        check(rd & 32'h4, 32'h4, "match flag");
        check({31'h0, io_o[0]}, 32'h1, "pin toggled");
        check(rd & 32'h8, 32'h8, "capture");
    endtask : t_chan
    // -------------------------------------------------------------
    // Sequence, verdict and watchdog
    // -------------------------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results
    initial
    begin
        repeat (8) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        t_reset();
        t_snap();
        t_step(cat_pkg::TB_DIV12, 1'b0, 4, 8'd4);
        t_step(cat_pkg::TB_DIV4, 1'b0, 4, 8'd12);
        t_step(cat_pkg::TB_SYSCLK, 1'b0, 4, 8'd48);
        t_step(cat_pkg::TB_T0OVF, 1'b0, 0, 8'd5);
        t_step(cat_pkg::TB_EXTIN, 1'b0, 2, 8'd5);
        t_step(cat_pkg::TB_EXTOSC, 1'b0, 1, 8'd5);
        t_step(cat_pkg::TB_RTC, 1'b0, 3, 8'd5);
        t_step(3'h7, 1'b0, 4, 8'd0);
        idle <= 1'b1;
        t_step(cat_pkg::TB_SYSCLK, 1'b1, 4, 8'd0);
        t_step(cat_pkg::TB_SYSCLK, 1'b0, 4, 8'd48);
        idle <= 1'b0;
        t_step(cat_pkg::TB_SYSCLK, 1'b1, 4, 8'd48);
        t_ovf();
        for (int k = 0; k < 4; k++)
        begin
            wb(1'b1, cat_pkg::OFF_CYCLEN, 8'(k));
            run_from((16'h1 << (7 + k)) - 16'h4, 32'h0);
            run_from((16'h1 << (8 + k)) - 16'h4, 32'h2);
        end
        t_chan();
        results();
    end
    // Hang guard
    initial
    begin
        repeat (20000) @(posedge mclk_i);
        n_fail++;
        results();
    end
endmodule : cat_counter_array_tb_top
`default_nettype wire
